// >>> rtl/ufi_pkg.sv
// Purpose: Shared constants and types for the FIFO and interrupt control.
// Assumes: One serial channel, 125 MHz register clock.
// Notes:   Register byte address is the register index times four.
package ufi_pkg;

	// Register indices, byte address is index times four.
	localparam logic [2:0] IDX_DATA = 3'h0;
	localparam logic [2:0] IDX_IER  = 3'h1;
	localparam logic [2:0] IDX_FCR  = 3'h2;
	localparam logic [2:0] IDX_LINE = 3'h3;
	localparam logic [2:0] IDX_LSR  = 3'h5;
	localparam logic [2:0] IDX_MSR  = 3'h6;

	// Field positions of fifo_control.
	localparam int FCR_EN    = 0;
	localparam int FCR_RXCLR = 1;
	localparam int FCR_TXCLR = 2;
	localparam int FCR_DMA   = 3;
	localparam int FCR_TRIG  = 6;

	// Field positions of interrupt_enable.
	localparam int IER_RX = 0;
	localparam int IER_TX = 1;
	localparam int IER_LS = 2;
	localparam int IER_MS = 3;

	// Identification codes, bits 3:0.
	localparam logic [3:0] IID_NONE = 4'h1;
	localparam logic [3:0] IID_LS   = 4'h6;
	localparam logic [3:0] IID_RDA  = 4'h4;
	localparam logic [3:0] IID_TO   = 4'hc;
	localparam logic [3:0] IID_TRANSMIT_HOLDING_EMPTY = 4'h2;
	localparam logic [3:0] IID_MS   = 4'h0;

	// Depth and receive trigger levels.
	localparam logic [4:0] DEPTH  = 5'h10;
	localparam logic [4:0] TRIG_1 = 5'h01;
	localparam logic [4:0] TRIG_4 = 5'h04;
	localparam logic [4:0] TRIG_8 = 5'h08;
	localparam logic [4:0] TRIG_E = 5'h0e;

	// Character timing: baud ticks are the 16x clock.
	localparam logic [3:0] BASE_BITS = 4'h7;
	localparam logic [3:0] ONE_BIT   = 4'h1;

	// Reset values.
	localparam logic [3:0] IER_RST  = 4'h0;
	localparam logic [3:0] LINE_RST = 4'h0;
	localparam logic [1:0] TRIG_RST = 2'h0;

	typedef struct packed {
		logic       brk;
		logic       frame;
		logic       parity;
		logic [7:0] data;
	} ufi_rx_s;

	typedef enum logic [2:0] {
		TX_FILLED = 3'b001,
		TX_DELAY  = 3'b010,
		TX_EMPTY  = 3'b100
	} ufi_tx_e;

endpackage

// >>> rtl/ufi_fifo.sv
// Purpose: Sixteen entry flop FIFO with flush and a variable capacity.
// Assumes: Push when full and pop when empty are ignored.
// Notes:   Capacity of one gives the character mode holding register.
`timescale 1ns/100ps
module ufi_fifo #(
	parameter int W = 11
) (
	// Clock and reset.
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	// Control.
	input  wire logic         flush_in,
	input  wire logic [4:0]   cap_in,
	// Write side.
	input  wire logic         push_in,
	input  wire logic [W-1:0] data_in,
	// Read side.
	input  wire logic         pop_in,
	output logic      [W-1:0] head_out,
	output logic      [4:0]   count_out,
	output logic              full_out
);
	logic [W-1:0] mem [16];
	logic [3:0]   rd_ptr;
	logic [3:0]   wr_ptr;
	logic         do_push;
	logic         do_pop;

	assign full_out = count_out >= cap_in;
	assign do_push  = push_in && !full_out;
	assign do_pop   = pop_in && (count_out != 5'h00);
	assign head_out = mem[rd_ptr];

	always_ff @(posedge clk_in) begin
		if (do_push && !flush_in) begin
			mem[wr_ptr] <= data_in;
		end
	end

	// Flush only resets pointers and count; head_out still shows the stale entry at index 0.
	always_ff @(posedge clk_in) begin
		if (rst_in || flush_in) begin
			rd_ptr    <= 4'h0;
			wr_ptr    <= 4'h0;
			count_out <= 5'h00;
		end else begin
			if (do_push) begin
				wr_ptr <= wr_ptr + 4'h1;
			end
			if (do_pop) begin
				rd_ptr <= rd_ptr + 4'h1;
			end
			if (do_push && !do_pop) begin
				count_out <= count_out + 5'h01;
			end else if (do_pop && !do_push) begin
				count_out <= count_out - 5'h01;
			end
		end
	end
endmodule

// >>> rtl/ufi_char_timer.sv
// Purpose: Counts 16x baud ticks up to a limit and pulses once there.
// Assumes: Restart has priority over counting.
// Notes:   After the pulse the timer holds until restarted.
`timescale 1ns/100ps
module ufi_char_timer (
	// Clock and reset.
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// Control.
	input  wire logic       restart_in,
	input  wire logic       run_in,
	input  wire logic       tick_in,
	input  wire logic [9:0] limit_in,
	// Result.
	output logic            fire_out
);
	logic [9:0] cnt;
	logic       done;

	always_ff @(posedge clk_in) begin
		if (rst_in || restart_in) begin
			cnt      <= 10'h000;
			done     <= 1'b0;
			fire_out <= 1'b0;
		end else begin
			fire_out <= 1'b0;
			if (run_in && tick_in && !done) begin
				if (cnt >= limit_in) begin
					done     <= 1'b1;
					fire_out <= 1'b1;
				end else begin
					cnt <= cnt + 10'h001;
				end
			end
		end
	end
endmodule

// >>> rtl/ufi_ctrl.sv
// Purpose: FIFO control and prioritized interrupts of one serial channel.
// Assumes: Avalon-MM slave, one wait state, baud16_tick_in from divider.
// Notes:   Data and line status bits come from the receiver shift logic.
`timescale 1ns/100ps
module ufi_ctrl (
	// Clock and reset.
	input  wire logic                  ref_clk_in,
	input  wire logic                  sys_rst_in,
	// Avalon-MM slave.
	input  wire logic [4:0]            avs_address_in,
	input  wire logic                  avs_read_in,
	input  wire logic                  avs_write_in,
	input  wire logic [31:0]           avs_writedata_in,
	input  wire logic [3:0]            avs_byteenable_in,
	output logic      [31:0]           avs_readdata_out,
	output logic                       avs_waitrequest_out,
	// Receiver shift logic.
	input  wire logic                  baud16_tick_in,
	input  wire logic                  rx_push_in,
	input  wire ufi_pkg::ufi_rx_s      rx_char_in,
	// Transmitter shift logic.
	input  wire logic                  tx_take_in,
	input  wire logic                  tx_shift_empty_in,
	output logic      [7:0]            tx_data_out,
	output logic                       tx_valid_out,
	// Modem lines {dcd, ri, dsr, cts}.
	input  wire logic [3:0]            modem_lines_in,
	// Interrupt and DMA.
	output logic                       channel_interrupt_out,
	output logic                       receive_dma_ready_out,
	output logic                       transmit_dma_ready_out
);
	logic          acc;
	logic          rd_acc;
	logic          wr_acc;
	logic [2:0]    idx;
	logic [7:0]    wd;
	logic          thr_wr;
	logic          rbr_rd;
	logic          ier_wr;
	logic          fcr_wr;
	logic          line_wr;
	logic          iir_rd;
	logic          lsr_rd;
	logic          msr_rd;
	logic          fifo_en;
	logic          dma_mode;
	logic [1:0]    trig_sel;
	logic [3:0]    interrupt_enable;
	logic [3:0]    line_cfg;
	logic          rx_flush;
	logic          tx_flush;
	logic [4:0]    cap;
	logic [4:0]    trig_lvl;
	ufi_pkg::ufi_rx_s rx_head;
	logic [4:0]    rx_count;
	logic          rx_full;
	logic [10:0]   tx_head;
	logic [4:0]    tx_count;
	logic          tx_pop;
	logic          rda;
	logic [3:0]    char_bits;
	logic [9:0]    to_limit;
	logic [9:0]    transmit_holding_empty_limit;
	logic          to_fire;
	logic          to_pend;
	logic          transmit_holding_empty_fire;
	ufi_pkg::ufi_tx_e tx_state;
	ufi_pkg::ufi_tx_e next_tx_state;
	logic          two_seen;
	logic          first_after;
	logic          transmit_holding_empty;
	logic          transmit_holding_empty_arm;
	logic          transmit_holding_empty_set;
	logic          transmit_holding_empty_pend;
	logic [3:0]    ls_err;
	logic [3:0]    lines_q;
	logic [3:0]    delta;
	logic [3:0]    chg;
	logic [3:0]    iid;
	logic [7:0]    line_status;
	logic [7:0]    rd_mux;

	// Bus decode; a request is taken at the edge where waitrequest is low.
	assign acc    = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
	assign rd_acc = acc && avs_read_in;
	assign wr_acc = acc && avs_write_in && avs_byteenable_in[0];
	assign idx    = avs_address_in[4:2];
	assign wd     = avs_writedata_in[7:0];

	assign thr_wr  = wr_acc && (idx == ufi_pkg::IDX_DATA);
	assign rbr_rd  = rd_acc && (idx == ufi_pkg::IDX_DATA);
	assign ier_wr  = wr_acc && (idx == ufi_pkg::IDX_IER);
	assign fcr_wr  = wr_acc && (idx == ufi_pkg::IDX_FCR);
	assign line_wr = wr_acc && (idx == ufi_pkg::IDX_LINE);
	assign iir_rd  = rd_acc && (idx == ufi_pkg::IDX_FCR);
	assign lsr_rd  = rd_acc && (idx == ufi_pkg::IDX_LSR);
	assign msr_rd  = rd_acc && (idx == ufi_pkg::IDX_MSR);

	// One wait state: the first request cycle always waits.
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			avs_waitrequest_out <= 1'b1;
		end else begin
			avs_waitrequest_out <=
				!((avs_read_in || avs_write_in) && avs_waitrequest_out);
		end
	end

	// Read data is sampled in the wait cycle and stands on the accept edge.
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (avs_read_in && avs_waitrequest_out) begin
			avs_readdata_out <= {24'h00_0000, rd_mux};
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			fifo_en  <= 1'b0;
			dma_mode <= 1'b0;
			trig_sel <= ufi_pkg::TRIG_RST;
		end else if (fcr_wr) begin
			fifo_en <= wd[ufi_pkg::FCR_EN];
			if (wd[ufi_pkg::FCR_EN]) begin
				dma_mode <= wd[ufi_pkg::FCR_DMA];
				trig_sel <= wd[ufi_pkg::FCR_TRIG +: 2];
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			interrupt_enable      <= ufi_pkg::IER_RST;
			line_cfg <= ufi_pkg::LINE_RST;
		end else begin
			if (ier_wr) begin
				interrupt_enable <= wd[3:0];
			end
			if (line_wr) begin
				line_cfg <= wd[3:0];
			end
		end
	end

	// A mode change flushes both; flush bits act only with enable set.
	// Writing enable low always empties both, even when already off.
	assign rx_flush = fcr_wr && (!wd[ufi_pkg::FCR_EN] || !fifo_en
		|| wd[ufi_pkg::FCR_RXCLR]);
	assign tx_flush = fcr_wr && (!wd[ufi_pkg::FCR_EN] || !fifo_en
		|| wd[ufi_pkg::FCR_TXCLR]);
	assign cap = fifo_en ? ufi_pkg::DEPTH : ufi_pkg::TRIG_1;

	always_comb begin
		unique case (trig_sel)
			2'b00: trig_lvl = ufi_pkg::TRIG_1;
			2'b01: trig_lvl = ufi_pkg::TRIG_4;
			2'b10: trig_lvl = ufi_pkg::TRIG_8;
			2'b11: trig_lvl = ufi_pkg::TRIG_E;
		endcase
		if (!fifo_en) begin
			trig_lvl = ufi_pkg::TRIG_1;
		end
	end

	// The shift registers sit outside; flushing never reaches them.
	ufi_fifo #(.W(11)) u_rx_fifo (
		.clk_in    (ref_clk_in),
		.rst_in    (sys_rst_in),
		.flush_in  (rx_flush),
		.cap_in    (cap),
		.push_in   (rx_push_in),
		.data_in   (rx_char_in),
		.pop_in    (rbr_rd),
		.head_out  (rx_head),
		.count_out (rx_count),
		.full_out  (rx_full)
	);

	ufi_fifo #(.W(11)) u_tx_fifo (
		.clk_in    (ref_clk_in),
		.rst_in    (sys_rst_in),
		.flush_in  (tx_flush),
		.cap_in    (cap),
		.push_in   (thr_wr),
		.data_in   ({3'h0, wd}),
		.pop_in    (tx_pop),
		.head_out  (tx_head),
		.count_out (tx_count),
		.full_out  ()
	);

	// The shifter may take only while tx_valid_out is high.
	assign tx_pop = tx_take_in && tx_valid_out;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			tx_valid_out <= 1'b0;
			tx_data_out  <= 8'h00;
		end else begin
			tx_valid_out <= (tx_count != 5'h00) && !tx_pop && !tx_flush;
			tx_data_out  <= tx_head[7:0];
		end
	end

	assign rda = rx_count >= trig_lvl;

	// Start, data, parity and stop bits, second stop included.
	assign char_bits = ufi_pkg::BASE_BITS + {2'h0, line_cfg[1:0]}
		+ {3'h0, line_cfg[2]} + {3'h0, line_cfg[3]};
	assign to_limit   = {char_bits, 6'h00} - 10'h001;
	assign transmit_holding_empty_limit = {2'h0, char_bits - ufi_pkg::ONE_BIT, 4'h0}
		- 10'h001;

	ufi_char_timer u_to_timer (
		.clk_in     (ref_clk_in),
		.rst_in     (sys_rst_in),
		.restart_in (rx_push_in || rbr_rd || rx_flush),
		.run_in     (fifo_en && (rx_count != 5'h00)),
		.tick_in    (baud16_tick_in),
		.limit_in   (to_limit),
		.fire_out   (to_fire)
	);

	// Polled mode gives no time-out indication at all.
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || rx_flush) begin
			to_pend <= 1'b0;
		end else if (to_fire && interrupt_enable[ufi_pkg::IER_RX]) begin
			to_pend <= 1'b1;
		end else if (rbr_rd) begin
			to_pend <= 1'b0;
		end
	end

	ufi_char_timer u_transmit_holding_empty_timer (
		.clk_in     (ref_clk_in),
		.rst_in     (sys_rst_in),
		.restart_in (tx_state != ufi_pkg::TX_DELAY),
		.run_in     (1'b1),
		.tick_in    (baud16_tick_in),
		.limit_in   (transmit_holding_empty_limit),
		.fire_out   (transmit_holding_empty_fire)
	);

	always_comb begin
		next_tx_state = tx_state;
		unique case (tx_state)
			ufi_pkg::TX_FILLED: begin
				if (tx_count == 5'h00 && !thr_wr) begin
					if (fifo_en && !two_seen && !first_after) begin
						next_tx_state = ufi_pkg::TX_DELAY;
					end else begin
						next_tx_state = ufi_pkg::TX_EMPTY;
					end
				end
			end
			ufi_pkg::TX_DELAY: begin
				if (thr_wr) begin
					next_tx_state = ufi_pkg::TX_FILLED;
				end else if (transmit_holding_empty_fire) begin
					next_tx_state = ufi_pkg::TX_EMPTY;
				end
			end
			ufi_pkg::TX_EMPTY: begin
				if (thr_wr) begin
					next_tx_state = ufi_pkg::TX_FILLED;
				end
			end
			default: next_tx_state = ufi_pkg::TX_EMPTY;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			tx_state <= ufi_pkg::TX_EMPTY;
		end else begin
			tx_state <= next_tx_state;
		end
	end

	// History since holding-empty last rose, and the mode-change marker.
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			two_seen    <= 1'b0;
			first_after <= 1'b0;
		end else begin
			if (tx_count >= 5'h02) begin
				two_seen <= 1'b1;
			end else if (next_tx_state == ufi_pkg::TX_EMPTY) begin
				two_seen <= 1'b0;
			end
			if (fcr_wr && (wd[ufi_pkg::FCR_EN] != fifo_en)) begin
				first_after <= 1'b1;
			end else if (tx_state != ufi_pkg::TX_EMPTY
				&& next_tx_state == ufi_pkg::TX_EMPTY) begin
				// Idling empty must not use up the marker.
				first_after <= 1'b0;
			end
		end
	end

	assign transmit_holding_empty     = tx_state == ufi_pkg::TX_EMPTY;
	assign transmit_holding_empty_set = transmit_holding_empty && interrupt_enable[ufi_pkg::IER_TX] && !transmit_holding_empty_arm;

	// Set wins over a clear that lands in the same cycle.
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			transmit_holding_empty_arm  <= 1'b0;
			transmit_holding_empty_pend <= 1'b0;
		end else begin
			transmit_holding_empty_arm <= transmit_holding_empty && interrupt_enable[ufi_pkg::IER_TX];
			if (transmit_holding_empty_set) begin
				transmit_holding_empty_pend <= 1'b1;
			end else if (thr_wr || !interrupt_enable[ufi_pkg::IER_TX]
				|| (iir_rd && iid == ufi_pkg::IID_TRANSMIT_HOLDING_EMPTY)) begin
				transmit_holding_empty_pend <= 1'b0;
			end
		end
	end

	// Line errors {break, framing, parity, overrun}; status keeps updating.
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			ls_err <= 4'h0;
		end else begin
			ls_err <= (lsr_rd ? 4'h0 : ls_err)
				| ({4{rx_push_in}} & {rx_char_in.brk,
				rx_char_in.frame, rx_char_in.parity, rx_full});
		end
	end

	assign chg = {modem_lines_in[3] ^ lines_q[3],
		lines_q[2] && !modem_lines_in[2],
		modem_lines_in[1:0] ^ lines_q[1:0]};

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			lines_q <= 4'h0;
			delta   <= 4'h0;
		end else begin
			lines_q <= modem_lines_in;
			delta   <= (msr_rd ? 4'h0 : delta) | chg;
		end
	end

	// Every source is gated by its enable, so all-clear means silence.
	always_comb begin
		if (interrupt_enable[ufi_pkg::IER_LS] && ls_err != 4'h0) begin
			iid = ufi_pkg::IID_LS;
		end else if (interrupt_enable[ufi_pkg::IER_RX] && rda) begin
			iid = ufi_pkg::IID_RDA;
		end else if (interrupt_enable[ufi_pkg::IER_RX] && to_pend) begin
			iid = ufi_pkg::IID_TO;
		end else if (interrupt_enable[ufi_pkg::IER_TX] && transmit_holding_empty_pend) begin
			iid = ufi_pkg::IID_TRANSMIT_HOLDING_EMPTY;
		end else if (interrupt_enable[ufi_pkg::IER_MS] && delta != 4'h0) begin
			iid = ufi_pkg::IID_MS;
		end else begin
			iid = ufi_pkg::IID_NONE;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			channel_interrupt_out <= 1'b0;
		end else begin
			channel_interrupt_out <= !iid[0];
		end
	end

	// Mode 0 signals any data or empty; mode 1 trigger or room.
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			receive_dma_ready_out  <= 1'b0;
			transmit_dma_ready_out <= 1'b0;
		end else if (fifo_en && dma_mode) begin
			receive_dma_ready_out  <= rda || to_pend;
			transmit_dma_ready_out <= tx_count < cap;
		end else begin
			receive_dma_ready_out  <= rx_count != 5'h00;
			transmit_dma_ready_out <= tx_count == 5'h00;
		end
	end

	assign line_status = {fifo_en && (rx_count != 5'h00)
			&& (rx_head.brk || rx_head.frame || rx_head.parity),
		transmit_holding_empty && tx_shift_empty_in, transmit_holding_empty, ls_err,
		rx_count != 5'h00};

	always_comb begin
		unique case (idx)
			ufi_pkg::IDX_DATA: rd_mux = rx_head.data;
			ufi_pkg::IDX_IER:  rd_mux = {4'h0, interrupt_enable};
			ufi_pkg::IDX_FCR:  rd_mux = {{2{fifo_en}}, 2'h0, iid};
			ufi_pkg::IDX_LINE: rd_mux = {4'h0, line_cfg};
			ufi_pkg::IDX_LSR:  rd_mux = line_status;
			ufi_pkg::IDX_MSR:  rd_mux = {lines_q, delta};
			default:           rd_mux = 8'h00;
		endcase
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	sequence s_fcr_en;
		fcr_wr && wd[ufi_pkg::FCR_EN];
	endsequence

	sequence s_iir_sample;
		avs_read_in && avs_waitrequest_out && idx == ufi_pkg::IDX_FCR;
	endsequence

	property p_fifo_off;
		fcr_wr && !wd[ufi_pkg::FCR_EN] |=> rx_count == 5'h00
			&& tx_count == 5'h00;
	endproperty
	a_fifo_off: assert property (p_fifo_off)
		else $error("fifo disable did not empty both fifos");

	property p_rx_flush;
		s_fcr_en and wd[ufi_pkg::FCR_RXCLR] |=> rx_count == 5'h00;
	endproperty
	a_rx_flush: assert property (p_rx_flush)
		else $error("receive flush left bytes");

	property p_tx_flush;
		s_fcr_en and wd[ufi_pkg::FCR_TXCLR] |=> tx_count == 5'h00;
	endproperty
	a_tx_flush: assert property (p_tx_flush)
		else $error("transmit flush left bytes");

	property p_trig14;
		s_fcr_en and wd[7:6] == 2'b11 |=> trig_lvl == 5'h0e;
	endproperty
	a_trig14: assert property (p_trig14)
		else $error("trigger field 11 did not give 14");

	property p_data_ready;
		rx_push_in && !rx_flush |=> line_status[0];
	endproperty
	a_data_ready: assert property (p_data_ready)
		else $error("data ready not set after arrival");

	property p_ls_first;
		s_iir_sample and (interrupt_enable[ufi_pkg::IER_LS] && ls_err != 4'h0)
			|=> avs_readdata_out[3:0] == ufi_pkg::IID_LS;
	endproperty
	a_ls_first: assert property (p_ls_first)
		else $error("line status not reported first");

	property p_to_clear;
		rbr_rd && !to_fire |=> !to_pend;
	endproperty
	a_to_clear: assert property (p_to_clear)
		else $error("time-out not cleared by data read");

	property p_thr_clear;
		thr_wr && !transmit_holding_empty_set |=> !transmit_holding_empty_pend;
	endproperty
	a_thr_clear: assert property (p_thr_clear)
		else $error("holding write did not clear interrupt");

	property p_irq_off;
		interrupt_enable == 4'h0 |=> !channel_interrupt_out;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("interrupt raised with all enables clear");

	property p_fifo_bits;
		s_iir_sample |=> avs_readdata_out[7:6] == {2{$past(fifo_en)}};
	endproperty
	a_fifo_bits: assert property (p_fifo_bits)
		else $error("identification bits 7:6 wrong");
endmodule

// >>> bench/ufi_serial_model.sv
// Purpose: Shifter side of the channel: baud ticks and transmit takes.
// Assumes: Divider gives one 16x tick every four clocks.
// Notes:   Takes a byte every other cycle, the fastest spacing allowed.
`timescale 1ns/100ps
module ufi_serial_model (
	// Clock and reset.
	input  wire logic ref_clk_in,
	input  wire logic sys_rst_in,
	// Transmit side.
	input  wire logic tx_valid_in,
	output logic      tx_take_out,
	// Baud timing.
	output logic      baud16_tick_out
);
	logic [1:0] div;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			div <= 2'h0;
			baud16_tick_out <= 1'b0;
		end else begin
			div <= div + 2'h1;
			baud16_tick_out <= (div == 2'h3);
		end
	end

	// Never back to back, so the take spacing of two cycles holds.
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			tx_take_out <= 1'b0;
		end else begin
			tx_take_out <= tx_valid_in && !tx_take_out;
		end
	end
endmodule

// >>> bench/ufi_ctrl_bench.sv
// Purpose: Register level tests of FIFO control and interrupts.
// Assumes: Avalon-MM master tasks; tick every four clocks.
// Notes:   Time-out wait bounds come from 448 ticks of four clocks.
`timescale 1ns/100ps
module ufi_ctrl_bench;
	logic                ref_clk_in = 1'b0;
	logic                sys_rst_in = 1'b1;
	logic [4:0]          addr = 5'h0;
	logic                rd = 1'b0;
	logic                wr = 1'b0;
	logic [31:0]         wdata = 32'h0;
	logic [31:0]         rdata;
	logic                wait_req;
	logic                tick;
	logic                rx_push = 1'b0;
	ufi_pkg::ufi_rx_s    rx_char = '0;
	logic                take;
	logic                tx_valid;
	logic [3:0]          modem = 4'h0;
	logic                irq;
	logic                rx_dma;
	logic                tx_dma;
	logic [7:0]          tx_data;
	logic [31:0]         q;
	int                  mismatches = 0;
	int                  n_tests = 0;
	int                  n;
	int                  lvl[4] = '{1, 4, 8, 14};

	ufi_ctrl DUT (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_req),
		.baud16_tick_in(tick), .rx_push_in(rx_push), .rx_char_in(rx_char),
		.tx_take_in(take), .tx_shift_empty_in(1'b1), .tx_data_out(tx_data),
		.tx_valid_out(tx_valid), .modem_lines_in(modem),
		.channel_interrupt_out(irq), .receive_dma_ready_out(rx_dma),
		.transmit_dma_ready_out(tx_dma));
	ufi_serial_model model (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.tx_valid_in(tx_valid), .tx_take_out(take), .baud16_tick_out(tick));

	initial begin
		forever #4 ref_clk_in = ~ref_clk_in;
	end

	task automatic finish_test();
		$display("mismatches %0d of %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask

	// Request is held until waitrequest is sampled low at an edge.
	task automatic bus(input logic w, input logic [2:0] idx,
		input logic [7:0] d, output logic [31:0] r);
		@(posedge ref_clk_in);
		wr <= w;
		rd <= !w;
		addr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		@(posedge ref_clk_in);
		while (wait_req !== 1'b0) begin
			@(posedge ref_clk_in);
		end
		r = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic push(input logic [7:0] d, input logic par);
		@(posedge ref_clk_in);
		rx_push <= 1'b1;
		rx_char <= '{brk: 1'b0, frame: 1'b0, parity: par, data: d};
		@(posedge ref_clk_in);
		rx_push <= 1'b0;
	endtask

	task automatic wr_reg(input logic [2:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, q);
	endtask

	task automatic rd_reg(input logic [2:0] idx);
		bus(1'b0, idx, 8'h0, q);
		repeat (2) @(posedge ref_clk_in);
	endtask

	// Counts clock edges until the interrupt output is seen high.
	task automatic wait_irq();
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge ref_clk_in);
			n++;
		end
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk_in);
		mismatches++;
		finish_test();
	end

	initial begin
		repeat (5) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		rd_reg(ufi_pkg::IDX_FCR);
		chk(q, 32'h01);
		wr_reg(ufi_pkg::IDX_IER, 8'hf0);
		rd_reg(ufi_pkg::IDX_IER);
		chk(q, 32'h00);
		$display("test reset done");
		wr_reg(ufi_pkg::IDX_IER, 8'h01);
		for (int t = 0; t < 4; t++) begin
			wr_reg(ufi_pkg::IDX_FCR, {t[1:0], 6'h03});
			for (int i = 1; i < lvl[t]; i++) begin
				push(8'(i), 1'b0);
			end
			repeat (2) @(posedge ref_clk_in);
			chk(32'(irq), 32'h0);
			push(8'haa, 1'b0);
			repeat (2) @(posedge ref_clk_in);
			chk(32'(irq), 32'h1);
			rd_reg(ufi_pkg::IDX_FCR);
			chk(q, 32'hc4);
			rd_reg(ufi_pkg::IDX_DATA);
			chk(q, (t == 0) ? 32'haa : 32'h01);
			chk(32'(irq), 32'h0);
		end
		$display("test trigger done");
		wr_reg(ufi_pkg::IDX_FCR, 8'hc3);
		push(8'h5a, 1'b0);
		wait_irq();
		chk(32'(n > 1700 && n < 1900), 32'h1);
		rd_reg(ufi_pkg::IDX_FCR);
		chk(q, 32'hcc);
		rd_reg(ufi_pkg::IDX_DATA);
		chk(q, 32'h5a);
		chk(32'(irq), 32'h0);
		$display("test time-out done");
		wr_reg(ufi_pkg::IDX_IER, 8'h05);
		wr_reg(ufi_pkg::IDX_FCR, 8'h03);
		push(8'h11, 1'b1);
		rd_reg(ufi_pkg::IDX_FCR);
		chk(q, 32'hc6);
		rd_reg(ufi_pkg::IDX_LSR);
		rd_reg(ufi_pkg::IDX_FCR);
		chk(q, 32'hc4);
		$display("test line status done");
		wr_reg(ufi_pkg::IDX_FCR, 8'h07);
		wr_reg(ufi_pkg::IDX_IER, 8'h02);
		rd_reg(ufi_pkg::IDX_FCR);
		chk(q, 32'hc2);
		rd_reg(ufi_pkg::IDX_FCR);
		chk(q, 32'hc1);
		// First byte after the mode change empties at once, then delayed.
		for (int b = 0; b < 2; b++) begin
			wr_reg(ufi_pkg::IDX_DATA, 8'h30 + 8'(b));
			repeat (2) @(posedge ref_clk_in);
			chk(32'(tx_data), 32'h30 + 32'(b));
			wait_irq();
			if (b == 0) begin
				chk(32'(n < 20), 32'h1);
			end else begin
				chk(32'(n > 370 && n < 410), 32'h1);
			end
			rd_reg(ufi_pkg::IDX_FCR);
			chk(q, 32'hc2);
		end
		$display("test transmit empty done");
		wr_reg(ufi_pkg::IDX_IER, 8'h08);
		modem <= 4'h1;
		rd_reg(ufi_pkg::IDX_FCR);
		chk(q, 32'hc0);
		rd_reg(ufi_pkg::IDX_MSR);
		chk(q, 32'h11);
		rd_reg(ufi_pkg::IDX_FCR);
		chk(q, 32'hc1);
		$display("test modem done");
		wr_reg(ufi_pkg::IDX_IER, 8'h00);
		push(8'h22, 1'b0);
		repeat (3) @(posedge ref_clk_in);
		chk(32'(irq), 32'h0);
		chk(32'(rx_dma), 32'h1);
		chk(32'(tx_dma), 32'h1);
		wr_reg(ufi_pkg::IDX_FCR, 8'h49);
		repeat (2) @(posedge ref_clk_in);
		chk(32'(rx_dma), 32'h0);
		rd_reg(ufi_pkg::IDX_LSR);
		chk(32'(q[0]), 32'h1);
		wr_reg(ufi_pkg::IDX_FCR, 8'h00);
		rd_reg(ufi_pkg::IDX_LSR);
		chk(32'(q[0]), 32'h0);
		rd_reg(ufi_pkg::IDX_FCR);
		chk(q, 32'h01);
		$display("test polled done");
		finish_test();
	end
endmodule
